// File: logic/rc_line_pkg.sv
/*
  Shared constants for the remote control line manager: the small register
  map, event bit positions, reset values, state codes and timing counts.
  Assumes a single 250 MHz core clock; all counts below are in its cycles.
*/
package rc_line_pkg;

  // Core clock rate.
  localparam int unsigned CLK_MHZ          = 250;

  // Momentary output hold time after the last activating message.
  localparam int unsigned HOLD_TIME_US     = 100;
  localparam int unsigned HOLD_CYCLES      = HOLD_TIME_US * CLK_MHZ;
  // Serial command bit time.
  localparam int unsigned BIT_TIME_US      = 10;
  localparam int unsigned BIT_CYCLES       = BIT_TIME_US * CLK_MHZ;
  // Pairing input held this long restores factory defaults.
  localparam int unsigned FACTORY_TIME_MS  = 1000;
  localparam int unsigned FACTORY_CYCLES   = FACTORY_TIME_MS * 1000 * CLK_MHZ;
  // Activity indicator flash period.
  localparam int unsigned FLASH_TIME_MS    = 250;
  localparam int unsigned FLASH_CYCLES     = FLASH_TIME_MS * 1000 * CLK_MHZ;

  // Register port.
  localparam int unsigned ADDR_W           = 2;
  localparam int unsigned DATA_W           = 8;
  localparam logic [1:0]  REG_STATUS       = 2'h0;
  localparam logic [1:0]  REG_MASK         = 2'h1;
  localparam logic [1:0]  REG_STATE        = 2'h2;
  localparam logic [1:0]  REG_CMD_BYTE     = 2'h3;

  // Event bits of the status and mask registers.
  localparam int unsigned EV_W             = 4;
  localparam int unsigned EV_MSG           = 0;
  localparam int unsigned EV_ACK           = 1;
  localparam int unsigned EV_PAIR          = 2;
  localparam int unsigned EV_CMD           = 3;
  localparam logic [3:0]  STATUS_RST       = 4'h0;
  localparam logic [3:0]  MASK_RST         = 4'h0;

  // Activity indicator flash lengths, in quarters of the period.
  localparam logic [1:0]  FLASH_NONE       = 2'h0;
  localparam logic [1:0]  FLASH_SHORT      = 2'h1;
  localparam logic [1:0]  FLASH_MEDIUM     = 2'h2;
  localparam logic [1:0]  FLASH_LONG       = 2'h3;

  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_RX      = 5'h02,
    ST_TX_CTRL = 5'h04,
    ST_TX_ACK  = 5'h08,
    ST_PAIR    = 5'h10
  } line_state_t;

endpackage

// File: logic/sync_2ff.sv
/*
  Two-stage synchroniser for a bundle of level signals.
  Assumes each bit is a slow level; no bit-to-bit coherence is promised.
*/
`timescale 1ns/1ns
module sync_2ff #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t q_r;
  sync_st_t q_nxt;

  generate
    if (W < 1) begin : g_bad_w
      $error("sync_2ff needs a width of at least one");
    end
  endgenerate

  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = d_i;
    q_nxt.s2 = q_r.s1;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r.s2;

endmodule

// File: logic/activity_flash.sv
/*
  Activity indicator flasher: a free running period counter and an on time
  of zero to three quarters of the period, chosen by the level input.
  Assumes the level input is a registered signal of the same clock.
*/
`timescale 1ns/1ns
module activity_flash #(
  parameter int unsigned PERIOD = rc_line_pkg::FLASH_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] level_i,
  output logic            ind_o
);

  localparam int unsigned CW      = $clog2(PERIOD);
  localparam int unsigned QUARTER = PERIOD / 4;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          ind;
  } flash_st_t;

  flash_st_t  q_r;
  flash_st_t  q_nxt;
  logic [CW+1:0] on_len;

  generate
    if (PERIOD < 8) begin : g_bad_period
      $error("activity_flash needs a period of at least eight cycles");
    end
  endgenerate

  always_comb begin
    q_nxt   = q_r;
    on_len  = (CW+2)'(QUARTER) * {{CW{1'b0}}, level_i};
    q_nxt.cnt = (q_r.cnt == CW'(PERIOD - 1)) ? '0 : q_r.cnt + 1'b1;
    q_nxt.ind = ({2'b00, q_r.cnt} < on_len);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign ind_o = q_r.ind;

endmodule

// File: logic/remote_control_line_manager.sv
/*
  Pin level control of a remote control transceiver: reset and power-down
  handling, latched or momentary control lines, acknowledgements, pairing,
  a serial command line with echo reply, amplifier enables and an activity
  indicator. A small register port gives events, a mask and an interrupt.
  Assumes the radio engine sits on the rx_/tx_/pair_ ports in this clock
  domain, and that pins arrive asynchronously and are synchronised here.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
// Function
// R1 - Activity indicator flashes, flash length showing the present state.
// R2 - Device stays reset while its reset pin is low.
// R3 - Serial commands are taken on the command input line.
// R4 - Power-down pin low gives a quiet non-functional low-power state.
// R5 - Latch mode: each activating message toggles and holds the line.
// R6 - Momentary mode: line active only while activating messages keep coming.
// R7 - Acknowledge enable high sends an acknowledgement after each valid message.
// R8 - Pairing input high starts pairing; long hold restores factory defaults.
// R9 - Replies to serial commands go out on the command output line.
// R10 - Receive amplifier enable is high while receiving, else low.
// R11 - Transmit amplifier enable is high while transmitting.
// R12 - Lower direction pin low makes lines 0 to 3 outputs.
// R13 - Upper direction pin low makes lines 4 to 7 outputs.
// R14 - Acknowledge received output rises when an answer follows our message.
// R15 - All pins pass two-flop synchronisers; pairing acts on its rising edge.
module remote_control_line_manager #(
  parameter int unsigned HOLD_CYCLES    = rc_line_pkg::HOLD_CYCLES,
  parameter int unsigned BIT_CYCLES     = rc_line_pkg::BIT_CYCLES,
  parameter int unsigned FACTORY_CYCLES = rc_line_pkg::FACTORY_CYCLES,
  parameter int unsigned FLASH_PERIOD   = rc_line_pkg::FLASH_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       reset_n_i,
  input  wire logic       power_down_n_i,
  input  wire logic       cmd_data_i,
  input  wire logic       latch_en_i,
  input  wire logic       ack_en_i,
  input  wire logic       pair_i,
  input  wire logic       lower_group_direction_i,
  input  wire logic       upper_group_direction_i,
  input  wire logic [7:0] control_lines_i,
  output logic      [7:0] control_lines_o,
  output logic      [7:0] control_lines_oe_n_o,
  output logic            activity_indicator_o,
  output logic            cmd_data_o,
  output logic            rx_amp_enable_o,
  output logic            tx_amp_enable_o,
  output logic            ack_received_o,
  input  wire logic       rx_msg_i,
  input  wire logic [7:0] rx_lines_i,
  input  wire logic       rx_ack_i,
  input  wire logic       tx_done_i,
  input  wire logic       pair_done_i,
  output logic            tx_start_o,
  output logic            tx_is_ack_o,
  output logic      [7:0] tx_lines_o,
  output logic            pair_start_o,
  output logic            defaults_o,
  input  wire logic [1:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            irq_o
);

  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned BW = $clog2(2 * BIT_CYCLES);
  localparam int unsigned FW = $clog2(FACTORY_CYCLES + 1);

  typedef struct packed {
    rc_line_pkg::line_state_t state;
    logic                     pair_prev;
    logic                     cmd_prev;
    logic [7:0]               out_lines;
    logic [7:0]               oe_n;
    logic [HW-1:0]            hold_cnt;
    logic [7:0]               in_prev;
    logic                     ack_pend;
    logic                     ack_rcv;
    logic                     tx_start;
    logic                     tx_is_ack;
    logic [7:0]               tx_lines;
    logic                     pair_start;
    logic [FW-1:0]            pair_cnt;
    logic                     defaults;
    logic                     rx_amp;
    logic                     tx_amp;
    logic                     rx_busy;
    logic [2:0]               rx_bit;
    logic [BW-1:0]            rx_cnt;
    logic [7:0]               rx_sh;
    logic [7:0]               cmd_byte;
    logic [7:0]               tx_sh;
    logic [3:0]               tx_bits;
    logic [BW-1:0]            tx_cnt;
    logic                     cmd_out;
    logic [3:0]               status;
    logic [3:0]               mask;
    logic [7:0]               rdata;
    logic                     irq;
  } mgr_st_t;

  mgr_st_t    q_r;
  mgr_st_t    q_nxt;
  logic [15:0] pins_s;
  logic        rstn_s;
  logic        pdn_s;
  logic        cmd_s;
  logic        latch_s;
  logic        ack_en_s;
  logic        pair_s;
  logic        lower_s;
  logic        upper_s;
  logic [7:0]  lines_s;
  logic        run;
  logic        pair_rise;
  logic [7:0]  dir_out_mask;
  logic [7:0]  in_now;
  logic [3:0]  ev;
  logic [3:0]  w1c;
  logic [1:0]  flash_level;
  logic        status_has_ack;

  generate
    if (BIT_CYCLES < 4 || HOLD_CYCLES < 2 || FACTORY_CYCLES < 2 || FLASH_PERIOD < 8) begin : g_bad_param
      $error("remote_control_line_manager parameters are too small");
    end
  endgenerate

  sync_2ff #(
    .W (16)
  ) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({reset_n_i, power_down_n_i, cmd_data_i, latch_en_i, ack_en_i, pair_i,
             lower_group_direction_i, upper_group_direction_i, control_lines_i}),
    .q_o   (pins_s)
  );  // see R15

  assign {rstn_s, pdn_s, cmd_s, latch_s, ack_en_s, pair_s, lower_s, upper_s, lines_s} = pins_s;
  assign run          = rstn_s & pdn_s;  // see R2
  assign pair_rise    = pair_s & ~q_r.pair_prev;  // see R15
  assign dir_out_mask = {{4{~upper_s}}, {4{~lower_s}}};
  assign in_now       = lines_s & ~dir_out_mask;

  always_comb begin
    q_nxt            = q_r;
    ev               = '0;
    w1c              = '0;
    q_nxt.tx_start   = 1'b0;
    q_nxt.pair_start = 1'b0;
    q_nxt.defaults   = 1'b0;
    q_nxt.pair_prev  = pair_s;
    q_nxt.cmd_prev   = cmd_s;
    q_nxt.oe_n       = ~dir_out_mask;  // see R12 R13

    // Momentary lines drop once no activating message refreshed them.
    if (q_r.hold_cnt != '0) begin
      q_nxt.hold_cnt = q_r.hold_cnt - 1'b1;
      if (q_r.hold_cnt == HW'(1) && !latch_s) begin
        q_nxt.out_lines = 8'h00;  // see R6
      end
    end

    case (q_r.state)
      rc_line_pkg::ST_OFF: begin
        if (run) begin
          q_nxt.state = rc_line_pkg::ST_RX;
        end
      end
      rc_line_pkg::ST_RX: begin
        if (pair_rise) begin
          q_nxt.pair_start = 1'b1;  // see R8
          q_nxt.state      = rc_line_pkg::ST_PAIR;
        end else if (rx_msg_i) begin
          ev[rc_line_pkg::EV_MSG] = 1'b1;
          if (latch_s) begin
            q_nxt.out_lines = q_r.out_lines ^ (rx_lines_i & dir_out_mask);  // see R5
          end else begin
            q_nxt.out_lines = rx_lines_i & dir_out_mask;  // see R6
            q_nxt.hold_cnt  = HW'(HOLD_CYCLES);
          end
          if (ack_en_s) begin
            q_nxt.tx_start  = 1'b1;  // see R7
            q_nxt.tx_is_ack = 1'b1;
            q_nxt.tx_lines  = 8'h00;
            q_nxt.state     = rc_line_pkg::ST_TX_ACK;
          end
        end else if (in_now != q_r.in_prev) begin
          q_nxt.tx_start  = 1'b1;
          q_nxt.tx_is_ack = 1'b0;
          q_nxt.tx_lines  = in_now;
          q_nxt.in_prev   = in_now;
          q_nxt.ack_pend  = 1'b1;
          q_nxt.ack_rcv   = 1'b0;
          q_nxt.state     = rc_line_pkg::ST_TX_CTRL;
        end
      end
      rc_line_pkg::ST_TX_CTRL, rc_line_pkg::ST_TX_ACK: begin
        if (tx_done_i) begin
          q_nxt.state = rc_line_pkg::ST_RX;
        end
      end
      rc_line_pkg::ST_PAIR: begin
        if (pair_done_i) begin
          ev[rc_line_pkg::EV_PAIR] = 1'b1;
          q_nxt.state              = rc_line_pkg::ST_RX;
        end
      end
      default: begin
        q_nxt.state = rc_line_pkg::ST_OFF;
      end
    endcase

    // An answer from the far unit counts only after our own control message.
    if (rx_ack_i && q_r.ack_pend) begin
      q_nxt.ack_rcv            = 1'b1;  // see R14
      q_nxt.ack_pend           = 1'b0;
      ev[rc_line_pkg::EV_ACK]  = 1'b1;
    end

    // A long hold of the pairing input asks for factory defaults.
    if (!pair_s) begin
      q_nxt.pair_cnt = '0;
    end else if (q_r.pair_cnt != FW'(FACTORY_CYCLES)) begin
      q_nxt.pair_cnt = q_r.pair_cnt + 1'b1;
      q_nxt.defaults = (q_r.pair_cnt == FW'(FACTORY_CYCLES - 1));  // see R8
    end

    // Serial command receiver: idle low, a high start bit, eight bits LSB first.
    // A start is a rising edge, so the tail of a high last data bit is not taken as a new start.
    if (!q_r.rx_busy) begin
      if (cmd_s && !q_r.cmd_prev) begin
        q_nxt.rx_busy = 1'b1;  // see R3
        q_nxt.rx_bit  = 3'h0;
        q_nxt.rx_cnt  = BW'(BIT_CYCLES + BIT_CYCLES / 2 - 1);
      end
    end else if (q_r.rx_cnt == '0) begin
      q_nxt.rx_sh  = {cmd_s, q_r.rx_sh[7:1]};
      q_nxt.rx_cnt = BW'(BIT_CYCLES - 1);
      q_nxt.rx_bit = q_r.rx_bit + 1'b1;
      if (q_r.rx_bit == 3'h7) begin
        q_nxt.rx_busy           = 1'b0;
        q_nxt.cmd_byte          = {cmd_s, q_r.rx_sh[7:1]};
        ev[rc_line_pkg::EV_CMD] = 1'b1;
      end
    end else begin
      q_nxt.rx_cnt = q_r.rx_cnt - 1'b1;
    end

    // Reply transmitter echoes each received byte that completes while it is idle, in the same framing.
    if (ev[rc_line_pkg::EV_CMD] && q_r.tx_bits == 4'h0) begin
      q_nxt.tx_sh   = q_nxt.cmd_byte;
      q_nxt.tx_bits = 4'h9;
      q_nxt.tx_cnt  = BW'(BIT_CYCLES - 1);
      q_nxt.cmd_out = 1'b1;  // see R9
    end else if (q_r.tx_bits != 4'h0) begin
      if (q_r.tx_cnt == '0) begin
        q_nxt.cmd_out = (q_r.tx_bits > 4'h1) ? q_r.tx_sh[0] : 1'b0;
        q_nxt.tx_sh   = {1'b0, q_r.tx_sh[7:1]};
        q_nxt.tx_bits = q_r.tx_bits - 1'b1;
        q_nxt.tx_cnt  = BW'(BIT_CYCLES - 1);
      end else begin
        q_nxt.tx_cnt = q_r.tx_cnt - 1'b1;
      end
    end

    // Reset pin or power-down pin low forces the quiet state.
    if (!run) begin
      q_nxt.state      = rc_line_pkg::ST_OFF;  // see R2 R4
      q_nxt.out_lines  = 8'h00;
      q_nxt.oe_n       = 8'hFF;
      q_nxt.hold_cnt   = '0;
      q_nxt.in_prev    = 8'h00;
      q_nxt.ack_pend   = 1'b0;
      q_nxt.ack_rcv    = 1'b0;
      q_nxt.tx_start   = 1'b0;
      q_nxt.tx_is_ack  = 1'b0;
      q_nxt.pair_start = 1'b0;
      q_nxt.pair_cnt   = '0;
      q_nxt.defaults   = 1'b0;
      q_nxt.rx_busy    = 1'b0;
      q_nxt.tx_bits    = 4'h0;
      q_nxt.cmd_out    = 1'b0;
      ev               = '0;
    end

    q_nxt.rx_amp = (q_nxt.state == rc_line_pkg::ST_RX);  // see R10
    q_nxt.tx_amp = (q_nxt.state == rc_line_pkg::ST_TX_CTRL) ||
                   (q_nxt.state == rc_line_pkg::ST_TX_ACK);  // see R11

    // Register port; a new event wins over a clear in the same cycle.
    if (reg_wr_i && reg_addr_i == rc_line_pkg::REG_STATUS) begin
      w1c = reg_wdata_i[3:0];
    end
    if (reg_wr_i && reg_addr_i == rc_line_pkg::REG_MASK) begin
      q_nxt.mask = reg_wdata_i[3:0];
    end
    q_nxt.status = (q_r.status & ~w1c) | ev;
    q_nxt.irq    = |(q_nxt.status & q_nxt.mask);
    q_nxt.rdata  = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        rc_line_pkg::REG_STATUS:   q_nxt.rdata = {4'h0, q_r.status};
        rc_line_pkg::REG_MASK:     q_nxt.rdata = {4'h0, q_r.mask};
        rc_line_pkg::REG_STATE:    q_nxt.rdata = {3'h0, q_r.state};
        rc_line_pkg::REG_CMD_BYTE: q_nxt.rdata = q_r.cmd_byte;
        default:                   q_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r        <= '0;
      q_r.state  <= rc_line_pkg::ST_OFF;
      q_r.oe_n   <= 8'hFF;
      q_r.status <= rc_line_pkg::STATUS_RST;
      q_r.mask   <= rc_line_pkg::MASK_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  always_comb begin
    case (q_r.state)
      rc_line_pkg::ST_RX:      flash_level = rc_line_pkg::FLASH_SHORT;
      rc_line_pkg::ST_TX_CTRL: flash_level = rc_line_pkg::FLASH_MEDIUM;
      rc_line_pkg::ST_TX_ACK:  flash_level = rc_line_pkg::FLASH_MEDIUM;
      rc_line_pkg::ST_PAIR:    flash_level = rc_line_pkg::FLASH_LONG;
      default:                 flash_level = rc_line_pkg::FLASH_NONE;
    endcase
  end

  activity_flash #(
    .PERIOD (FLASH_PERIOD)
  ) u_flash (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (flash_level),
    .ind_o   (activity_indicator_o)
  );  // see R1

  assign control_lines_o      = q_r.out_lines;
  assign control_lines_oe_n_o = q_r.oe_n;
  assign cmd_data_o           = q_r.cmd_out;
  assign rx_amp_enable_o      = q_r.rx_amp;
  assign tx_amp_enable_o      = q_r.tx_amp;
  assign ack_received_o       = q_r.ack_rcv;
  assign tx_start_o           = q_r.tx_start;
  assign tx_is_ack_o          = q_r.tx_is_ack;
  assign tx_lines_o           = q_r.tx_lines;
  assign pair_start_o         = q_r.pair_start;
  assign defaults_o           = q_r.defaults;
  assign reg_rdata_o          = q_r.rdata;
  assign irq_o                = q_r.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_msg_in_rx;
    run && (q_r.state == rc_line_pkg::ST_RX) && !pair_rise && rx_msg_i;
  endsequence

  sequence s_byte_done;
    run && q_r.rx_busy && (q_r.rx_cnt == '0) && (q_r.rx_bit == 3'h7) && (q_r.tx_bits == 4'h0);
  endsequence

  a_flash_off: assert property ((q_r.state == rc_line_pkg::ST_OFF) |=> !activity_indicator_o) // see R1
    else $error("indicator lit while the device is off");
  a_reset_quiet: assert property (!rstn_s |=> (q_r.state == rc_line_pkg::ST_OFF) && !tx_start_o) // see R2
    else $error("device not held off by its reset pin");
  a_cmd_start: assert property ((run && !q_r.rx_busy && cmd_s && !q_r.cmd_prev) |=> q_r.rx_busy) // see R3
    else $error("serial start bit not taken");
  a_power_quiet: assert property (!pdn_s |=> !rx_amp_enable_o && !tx_amp_enable_o && (control_lines_oe_n_o == 8'hFF)) // see R4
    else $error("outputs active in power-down");
  a_latch_toggle: assert property (s_msg_in_rx ##0 latch_s |=> control_lines_o == ($past(control_lines_o) ^ $past(rx_lines_i & dir_out_mask))) // see R5
    else $error("latched line did not toggle");
  a_moment_drop: assert property ((run && !latch_s && q_r.hold_cnt == HW'(1) && !rx_msg_i) |=> control_lines_o == 8'h00) // see R6
    else $error("momentary line did not drop");
  a_ack_sent: assert property (s_msg_in_rx ##0 ack_en_s |=> tx_start_o && tx_is_ack_o ##1 tx_amp_enable_o) // see R7
    else $error("acknowledgement not sent");
  a_no_ack: assert property (s_msg_in_rx ##0 !ack_en_s |=> !(tx_start_o && tx_is_ack_o)) // see R7
    else $error("acknowledgement sent while disabled");
  a_pair_start: assert property ((run && q_r.state == rc_line_pkg::ST_RX && pair_rise) |=> pair_start_o && (q_r.state == rc_line_pkg::ST_PAIR)) // see R8
    else $error("pairing not started");
  a_cmd_reply: assert property (s_byte_done |=> cmd_data_o && (q_r.tx_bits == 4'h9)) // see R9
    else $error("no reply to serial command");
  a_rx_amp: assert property (rx_amp_enable_o == (q_r.state == rc_line_pkg::ST_RX)) // see R10
    else $error("receive amplifier enable wrong");
  a_tx_amp: assert property (tx_amp_enable_o == (q_r.state inside {rc_line_pkg::ST_TX_CTRL, rc_line_pkg::ST_TX_ACK})) // see R11
    else $error("transmit amplifier enable wrong");
  a_lower_dir: assert property (run |=> control_lines_oe_n_o[3:0] == {4{$past(lower_s)}}) // see R12
    else $error("lower group direction wrong");
  a_upper_dir: assert property (run |=> control_lines_oe_n_o[7:4] == {4{$past(upper_s)}}) // see R13
    else $error("upper group direction wrong");
  a_ack_seen: assert property ((run && q_r.ack_pend && rx_ack_i) |=> ack_received_o && status_has_ack) // see R14
    else $error("acknowledge received not raised");
  a_pair_edge: assert property ((pair_s && q_r.pair_prev) |=> !pair_start_o) // see R15
    else $error("pairing restarted without a rising edge");

  assign status_has_ack = q_r.status[rc_line_pkg::EV_ACK];

endmodule

// File: test/radio_model.sv
/*
  Behavioural radio engine at the far side of the line manager.
  Assumes one clock; start pulses are one cycle and sampled at rising edges.
*/
`timescale 1ns/1ns
module radio_model (
  input  wire logic clk_i,
  input  wire logic tx_start_i,
  input  wire logic tx_is_ack_i,
  input  wire logic pair_start_i,
  input  wire logic ack_reply_i,
  input  wire logic [7:0] dly_i,
  output logic      tx_done_o,
  output logic      pair_done_o,
  output logic      rx_ack_o
);
  logic kind;
  initial begin
    tx_done_o = 1'b0;
    pair_done_o = 1'b0;
    rx_ack_o = 1'b0;
  end
  // A control message may be answered by the far unit once it has gone out.
  always begin
    @(posedge clk_i);
    if (tx_start_i === 1'b1) begin
      kind = tx_is_ack_i;
      repeat (dly_i) @(posedge clk_i);
      tx_done_o <= 1'b1;
      @(posedge clk_i) tx_done_o <= 1'b0;
      if (!kind && ack_reply_i) begin
        repeat (dly_i) @(posedge clk_i);
        rx_ack_o <= 1'b1;
        @(posedge clk_i) rx_ack_o <= 1'b0;
      end
    end
  end
  always begin
    @(posedge clk_i);
    if (pair_start_i === 1'b1) begin
      repeat (dly_i) @(posedge clk_i);
      pair_done_o <= 1'b1;
      @(posedge clk_i) pair_done_o <= 1'b0;
    end
  end
endmodule

// File: test/remote_control_line_manager_tb.sv
/*
  Self-checking bench for the line manager: register port, radio pulses,
  pins and the serial line. Assumes the radio model above on the far side.
*/
`timescale 1ns/1ns
module remote_control_line_manager_tb;
  localparam int BIT = 8;
  logic clk_i = 1'b0, rst_i = 1'b1, reset_n_i = 1'b0, power_down_n_i = 1'b1, cmd_data_i = 1'b0;
  logic latch_en_i = 1'b1, ack_en_i = 1'b0, pair_i = 1'b0, lo_dir = 1'b0, up_dir = 1'b0;
  logic [7:0] control_lines_i = 8'h00, rx_lines_i = 8'h00, reg_wdata_i = 8'h00, dly = 8'h03;
  logic rx_msg_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, ack_reply = 1'b1;
  logic [1:0] reg_addr_i = 2'h0;
  logic [7:0] control_lines_o, control_lines_oe_n_o, tx_lines_o, reg_rdata_o;
  logic activity_indicator_o, cmd_data_o, rx_amp_enable_o, tx_amp_enable_o, ack_received_o, irq_o;
  logic tx_done_i, pair_done_i, rx_ack_i, tx_start_o, tx_is_ack_o, pair_start_o, defaults_o;
  int miscompares = 0, compares = 0, ons;
  always #2 clk_i = ~clk_i;
  remote_control_line_manager #(.HOLD_CYCLES(20), .BIT_CYCLES(BIT), .FACTORY_CYCLES(50), .FLASH_PERIOD(16)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .power_down_n_i(power_down_n_i),
    .cmd_data_i(cmd_data_i), .latch_en_i(latch_en_i), .ack_en_i(ack_en_i), .pair_i(pair_i),
    .lower_group_direction_i(lo_dir), .upper_group_direction_i(up_dir), .control_lines_i(control_lines_i),
    .control_lines_o(control_lines_o), .control_lines_oe_n_o(control_lines_oe_n_o),
    .activity_indicator_o(activity_indicator_o), .cmd_data_o(cmd_data_o), .rx_amp_enable_o(rx_amp_enable_o),
    .tx_amp_enable_o(tx_amp_enable_o), .ack_received_o(ack_received_o), .rx_msg_i(rx_msg_i),
    .rx_lines_i(rx_lines_i), .rx_ack_i(rx_ack_i), .tx_done_i(tx_done_i), .pair_done_i(pair_done_i),
    .tx_start_o(tx_start_o), .tx_is_ack_o(tx_is_ack_o), .tx_lines_o(tx_lines_o), .pair_start_o(pair_start_o),
    .defaults_o(defaults_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  radio_model partner (.clk_i(clk_i), .tx_start_i(tx_start_o), .tx_is_ack_i(tx_is_ack_o),
    .pair_start_i(pair_start_o), .ack_reply_i(ack_reply), .dly_i(dly), .tx_done_o(tx_done_i),
    .pair_done_o(pair_done_i), .rx_ack_o(rx_ack_i));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i) begin reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1; end
    @(posedge clk_i) reg_wr_i <= 1'b0;
  endtask
  task rdr(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_i) begin reg_addr_i <= a; reg_rd_i <= 1'b1; end
    @(posedge clk_i) reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  task msg(input logic [7:0] l);
    @(posedge clk_i) begin rx_msg_i <= 1'b1; rx_lines_i <= l; end
    @(posedge clk_i) rx_msg_i <= 1'b0;
    #1;
  endtask
  task automatic wt(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000 miscompares++;
    finish_test;
  end
  initial begin
    cyc(2);
    rst_i <= 1'b0;
    rdr(rc_line_pkg::REG_STATE, 8'h01);
    reset_n_i <= 1'b1;
    cyc(5);
    rdr(rc_line_pkg::REG_STATE, 8'h02);
    wr(rc_line_pkg::REG_MASK, 8'h01);
    msg(8'h01);
    chk(control_lines_o, 8'h01);
    chk(tx_start_o, 1'b0);
    chk(control_lines_oe_n_o, 8'h00);
    cyc(1);
    chk(irq_o, 1'b1);
    rdr(rc_line_pkg::REG_STATUS, 8'h01);
    wr(rc_line_pkg::REG_STATUS, 8'h01);
    wr(rc_line_pkg::REG_STATE, 8'hFF);
    rdr(rc_line_pkg::REG_STATE, 8'h02);
    chk(irq_o, 1'b0);
    msg(8'h01);
    chk(control_lines_o, 8'h00);
    latch_en_i <= 1'b0;
    ack_en_i <= 1'b1;
    cyc(4);
    msg(8'h02);
    chk({tx_start_o, tx_is_ack_o, tx_amp_enable_o, rx_amp_enable_o}, 8'h0E);
    chk(control_lines_o, 8'h02);
    wt(rx_amp_enable_o, 30);
    chk(rx_amp_enable_o, 1'b1);
    cyc(25);
    chk(control_lines_o, 8'h00);
    ons = 0;
    for (int k = 0; k < 16; k++) begin
      cyc(1);
      ons += activity_indicator_o;
    end
    chk(ons[7:0], 8'h04);
    ack_en_i <= 1'b0;
    up_dir <= 1'b1;
    dly <= 8'h0C;
    cyc(4);
    chk(control_lines_oe_n_o, 8'hF0);
    control_lines_i <= 8'h10;
    wt(tx_start_o, 20);
    chk({tx_start_o, tx_is_ack_o, tx_lines_o[4]}, 8'h05);
    wt(ack_received_o, 60);
    chk(ack_received_o, 1'b1);
    pair_i <= 1'b1;
    wt(pair_start_o, 20);
    chk(pair_start_o, 1'b1);
    wt(defaults_o, 80);
    chk(defaults_o, 1'b1);
    pair_i <= 1'b0;
    cyc(30);
    @(posedge clk_i) cmd_data_i <= 1'b1;
    repeat (BIT) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      cmd_data_i <= ((8'hA5 >> k) & 8'h01) != 8'h00;
      repeat (BIT) @(posedge clk_i);
    end
    cmd_data_i <= 1'b0;
    wt(cmd_data_o, 200);
    repeat (BIT / 2) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      cyc(BIT);
      chk(cmd_data_o, 8'hA5 >> k & 8'h01);
    end
    rdr(rc_line_pkg::REG_CMD_BYTE, 8'hA5);
    power_down_n_i <= 1'b0;
    cyc(5);
    chk(control_lines_oe_n_o, 8'hFF);
    chk({rx_amp_enable_o, tx_amp_enable_o}, 8'h00);
    rdr(rc_line_pkg::REG_STATE, 8'h01);
    finish_test;
  end
endmodule
